//--- verilog/gsp_gear_pulse.sv
// Electronic gear scaling and quadrature pulse regeneration with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "gsp_map.svh"
module gsp_gear_pulse #(
    parameter int unsigned ENC_RES = `GSP_ENC_RES_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic enc_step,
    input wire logic enc_dir,
    output logic quad_out_a,
    output logic quad_out_a_n,
    output logic quad_out_b,
    output logic quad_out_b_n,
    output logic index_out,
    output logic index_out_n,
    output logic [31:0] cmd_counts,
    output logic cmd_valid,
    output logic gear_alarm,
    output logic pulse_alarm
);
    localparam logic [31:0] RES_W = 32'(ENC_RES);

    if (ENC_RES < 64 || ENC_RES > 1073741824)
    begin : g_res_check
        $error("Encoder resolution out of range");
    end

    function automatic logic gear_bad(input logic [31:0] num, input logic [31:0] den);
        logic [63:0] n64;
        logic [63:0] d64;
        n64 = {32'h0, num};
        d64 = {32'h0, den};
        gear_bad = num == 32'h0 || den == 32'h0 || num > `GSP_GEAR_MAX || den > `GSP_GEAR_MAX ||
            n64 * `GSP_RATIO_INV_MIN < d64 || n64 > d64 * `GSP_RATIO_MAX;
    endfunction

    function automatic logic pulse_bad(input logic [31:0] ppr);
        logic [31:0] mask;
        mask = ppr > `GSP_PPR_STEP16 ? 32'hf : ppr > `GSP_PPR_STEP8 ? 32'h7 :
            ppr > `GSP_PPR_STEP4 ? 32'h3 : ppr > `GSP_PPR_STEP2 ? 32'h1 : 32'h0;
        pulse_bad = ppr < `GSP_PPR_MIN || ppr > `GSP_PPR_MAX || {ppr, 2'b00} > {2'b00, RES_W} ||
            (ppr & mask) != 32'h0;
    endfunction

    gsp_pkg::gsp_state_t s;
    gsp_pkg::gsp_state_t n;
    logic accept;
    logic fin;
    logic busy;
    logic restart;

    assign accept = hsel && htrans[1] && hready && s.ready;
    assign busy = s.div != gsp_pkg::GSP_IDLE;
    assign fin = s.dph && !(s.dwr && s.daddr == `GSP_OFF_POS_REF && busy);
    assign restart = fin && s.dwr && s.daddr == `GSP_OFF_CTRL && hwdata[`GSP_CTRL_RESTART];

    always_comb
    begin
        logic [31:0] step4;
        logic [32:0] sum;
        logic [63:0] r;
        logic [63:0] q;
        logic signed [63:0] sd;
        logic signed [63:0] sn;
        logic signed [63:0] tot;
        n = s;
        n.cmd_valid = 1'b0;
        step4 = {s.active.ppr[29:0], 2'b00};
        sum = 33'h0;
        r = 64'h0;
        q = 64'h0;
        sd = {{32{s.delta[31]}}, s.delta};
        sn = {32'h0, s.active.num};
        tot = 64'sh0;
        // Bus address phase capture
        if (accept)
        begin
            n.dph = 1'b1;
            n.dwr = hwrite;
            n.daddr = haddr[7:0];
            n.ready = 1'b0;
        end
        if (fin)
        begin
            n.dph = 1'b0;
            n.ready = 1'b1;
            if (s.dwr)
            begin
                case (s.daddr)
                    `GSP_OFF_GEAR_NUM: n.shadow.num = hwdata;
                    `GSP_OFF_GEAR_DEN: n.shadow.den = hwdata;
                    `GSP_OFF_PPR: n.shadow.ppr = hwdata;
                    `GSP_OFF_CTRL:
                    begin
                        n.dir_sel = hwdata[`GSP_CTRL_DIR];
                        if (hwdata[`GSP_CTRL_RESTART])
                        begin
                            n.active = s.shadow;
                        end
                    end
                    `GSP_OFF_POS_REF:
                    begin
                        if (!s.gear_al)
                        begin
                            n.delta = hwdata;
                            n.div = gsp_pkg::GSP_MUL;
                        end
                    end
                    default: n.rdata = s.rdata;
                endcase
            end
            else
            begin
                case (s.daddr)
                    `GSP_OFF_GEAR_NUM: n.rdata = s.shadow.num;
                    `GSP_OFF_GEAR_DEN: n.rdata = s.shadow.den;
                    `GSP_OFF_PPR: n.rdata = s.shadow.ppr;
                    `GSP_OFF_CTRL: n.rdata = {31'h0, s.dir_sel};
                    `GSP_OFF_STATUS: n.rdata = {29'h0, busy, s.pulse_al, s.gear_al};
                    `GSP_OFF_CMD_POS: n.rdata = s.cmd_pos;
                    `GSP_OFF_OUT_POS: n.rdata = s.qs;
                    default: n.rdata = 32'h0;
                endcase
            end
        end
        // Scale reference by numerator over denominator
        case (s.div)
            gsp_pkg::GSP_IDLE: n.cnt = 7'h0;
            gsp_pkg::GSP_MUL:
            begin
                // Remainder from last reference added in
                tot = sd * sn + $signed(s.carry);
                n.neg = tot[63];
                n.quo = tot[63] ? 64'(-tot) : 64'(tot);
                n.rem = 64'h0;
                n.cnt = 7'h0;
                n.div = gsp_pkg::GSP_DIV;
            end
            gsp_pkg::GSP_DIV:
            begin
                r = {s.rem[62:0], s.quo[63]};
                q = {s.quo[62:0], 1'b0};
                if (r >= {32'h0, s.active.den})
                begin
                    r = r - {32'h0, s.active.den};
                    q[0] = 1'b1;
                end
                n.rem = r;
                n.quo = q;
                n.cnt = 7'(s.cnt + 7'h1);
                if (s.cnt == `GSP_DIV_LAST)
                begin
                    n.div = gsp_pkg::GSP_DONE;
                end
            end
            gsp_pkg::GSP_DONE:
            begin
                q = s.neg ? 64'(-s.quo) : s.quo;
                // Signed remainder kept for next reference
                n.carry = s.neg ? 64'(-s.rem) : s.rem;
                n.cmd_out = q[31:0];
                n.cmd_pos = 32'(s.cmd_pos + q[31:0]);
                n.cmd_valid = 1'b1;
                n.div = gsp_pkg::GSP_IDLE;
            end
            default: n.div = gsp_pkg::GSP_IDLE;
        endcase
        n.gear_al = gear_bad(s.active.num, s.active.den);
        n.pulse_al = pulse_bad(s.active.ppr);
        // Divide encoder counts down to output edges
        if (enc_step && !s.pulse_al)
        begin
            if (enc_dir)
            begin
                sum = {1'b0, s.acc} + {1'b0, step4};
                if (sum >= {1'b0, RES_W})
                begin
                    n.acc = 32'(sum - {1'b0, RES_W});
                    // Edge count wraps after four edges per pulse times pulses per revolution
                    n.qs = (s.qs == 32'(step4 - 32'h1)) ? 32'h0 : 32'(s.qs + 32'h1);
                end
                else
                begin
                    n.acc = sum[31:0];
                end
            end
            else if (s.acc >= step4)
            begin
                n.acc = 32'(s.acc - step4);
            end
            else
            begin
                n.acc = 32'(s.acc + RES_W - step4);
                n.qs = (s.qs == 32'h0) ? 32'(step4 - 32'h1) : 32'(s.qs - 32'h1);
            end
        end
        if (restart)
        begin
            n.acc = 32'h0;
            n.qs = 32'h0;
            n.carry = 64'h0;
            n.cmd_pos = 32'h0;
            n.cmd_valid = 1'b0;
            n.div = gsp_pkg::GSP_IDLE;
        end
        // Gray sequence gives 90 degree phases
        // Direction select does not alter phase form
        n.quad.a = n.qs[0] ^ n.qs[1];
        n.quad.b = n.qs[1];
        // Index on first A pulse of each revolution
        n.quad.c = n.qs[31:2] == 30'h0 && (n.qs[0] ^ n.qs[1]);
        n.quad.a_n = !n.quad.a;
        n.quad.b_n = !n.quad.b;
        n.quad.c_n = !n.quad.c;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
            s.shadow <= '{`GSP_GEAR_DEF, `GSP_GEAR_DEF, `GSP_PPR_DEF};
            s.active <= '{`GSP_GEAR_DEF, `GSP_GEAR_DEF, `GSP_PPR_DEF};
            s.ready <= 1'b1;
            s.div <= gsp_pkg::GSP_IDLE;
            s.quad <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        end
        else if (ce)
        begin
            s <= n;
        end
    end

    // Feedback pins driven straight from state
    assign quad_out_a = s.quad.a;
    assign quad_out_a_n = s.quad.a_n;
    assign quad_out_b = s.quad.b;
    assign quad_out_b_n = s.quad.b_n;
    assign index_out = s.quad.c;
    assign index_out_n = s.quad.c_n;
    assign hreadyout = s.ready;
    assign hrdata = s.rdata;
    assign hresp = 1'b0;
    assign cmd_counts = s.cmd_out;
    assign cmd_valid = s.cmd_valid;
    assign gear_alarm = s.gear_al;
    assign pulse_alarm = s.pulse_al;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn || !ce);

    sequence restart_write;
        fin && s.dwr && s.daddr == `GSP_OFF_CTRL && hwdata[`GSP_CTRL_RESTART];
    endsequence

    sequence ref_taken;
        fin && s.dwr && s.daddr == `GSP_OFF_POS_REF && !s.gear_al;
    endsequence

    sequence ref_refused;
        fin && s.dwr && s.daddr == `GSP_OFF_POS_REF && s.gear_al;
    endsequence

    chk_quad_one_edge: assert property (!($changed(quad_out_a) && $changed(quad_out_b)))
        else $error("A and B changed together");
    chk_pair_opposite: assert property (quad_out_a_n != quad_out_a && quad_out_b_n != quad_out_b &&
        index_out_n != index_out)
        else $error("Complementary output not inverted");
    chk_index_width: assert property (index_out |-> quad_out_a)
        else $error("Index high outside phase A pulse");
    chk_index_place: assert property ($rose(index_out) |-> s.qs == 32'h1 || s.qs == 32'h2)
        else $error("Index rose away from revolution start");
    chk_gear_range: assert property (1'b1 |=> gear_alarm == $past(gear_bad(s.active.num, s.active.den)))
        else $error("Gear alarm does not follow ratio range");
    chk_pulse_range: assert property (1'b1 |=> pulse_alarm == $past(pulse_bad(s.active.ppr)))
        else $error("Pulse alarm does not follow setting");
    chk_restart_load: assert property (restart_write |=> s.active == $past(s.shadow) && s.qs == 32'h0)
        else $error("Restart did not load settings");
    chk_scale_done: assert property (ref_taken |-> ##67 cmd_valid)
        else $error("Scaled reference not produced in time");
    chk_carry_bound: assert property (!busy && s.carry != 64'h0 |->
        (s.carry[63] ? 64'(-s.carry) : s.carry) < {32'h0, s.active.den})
        else $error("Carried remainder not below denominator");
    chk_ref_refused: assert property (ref_refused |=> !busy && !cmd_valid)
        else $error("Reference accepted while gear alarm set");
    chk_restart_clear: assert property (restart_write |=> !busy && s.cmd_pos == 32'h0 && s.carry == 64'h0)
        else $error("Restart left scaler state behind");
    chk_alarm_blocks: assert property (pulse_alarm && enc_step && !restart |=> $stable(s.qs))
        else $error("Output edge moved during pulse alarm");
    chk_ce_freeze: assert property (@(posedge hclk) disable iff (!hresetn) !ce |=> $stable(s))
        else $error("State changed with clock enable low");
    chk_valid_single: assert property (cmd_valid |=> !cmd_valid)
        else $error("Scaled reference strobe longer than one cycle");
    chk_bus_wait: assert property (accept |=> !hreadyout)
        else $error("No wait state after address phase");
    chk_stall_ref: assert property (s.dph && s.dwr && s.daddr == `GSP_OFF_POS_REF && busy |-> !hreadyout)
        else $error("Reference write not stalled while scaler busy");
    chk_index_rev: assert property (index_out |-> s.qs[31:2] == 30'h0)
        else $error("Index high outside first pulse of revolution");
    chk_out_range: assert property (s.qs == 32'h0 || s.qs < {s.active.ppr[29:0], 2'b00})
        else $error("Edge position beyond pulses per revolution");
    chk_scale_start: assert property (ref_taken |=> s.div == gsp_pkg::GSP_MUL)
        else $error("Scaler did not start on reference");
endmodule
`default_nettype wire

//--- verilog/gsp_map.svh
// Register offsets, field positions, reset values and limits for the gear and pulse block
`ifndef GSP_MAP_SVH
`define GSP_MAP_SVH
`define GSP_OFF_GEAR_NUM 8'h00
`define GSP_OFF_GEAR_DEN 8'h04
`define GSP_OFF_PPR 8'h08
`define GSP_OFF_CTRL 8'h0c
`define GSP_OFF_STATUS 8'h10
`define GSP_OFF_POS_REF 8'h14
`define GSP_OFF_CMD_POS 8'h18
`define GSP_OFF_OUT_POS 8'h1c
`define GSP_CTRL_DIR 0
`define GSP_CTRL_RESTART 1
`define GSP_ST_GEAR_AL 0
`define GSP_ST_PULSE_AL 1
`define GSP_ST_BUSY 2
`define GSP_GEAR_DEF 32'h00000001
`define GSP_GEAR_MAX 32'h40000000
`define GSP_PPR_DEF 32'h00000800
`define GSP_PPR_MIN 32'h00000010
`define GSP_PPR_MAX 32'h00040000
`define GSP_PPR_STEP2 32'h00004000
`define GSP_PPR_STEP4 32'h00008000
`define GSP_PPR_STEP8 32'h00010000
`define GSP_PPR_STEP16 32'h00020000
`define GSP_RATIO_INV_MIN 64'h00000000000003e8
`define GSP_RATIO_MAX 64'h0000000000000fa0
`define GSP_DIV_LAST 7'h3f
`define GSP_ENC_RES_DEF 1048576
`endif

//--- verilog/gsp_pkg.sv
// Types shared by the gear scaling and pulse output block
`default_nettype none
package gsp_pkg;
    typedef enum logic [3:0] {
        GSP_IDLE = 4'h1,
        GSP_MUL = 4'h2,
        GSP_DIV = 4'h4,
        GSP_DONE = 4'h8
    } gsp_div_t;
    typedef struct packed {
        logic [31:0] num;
        logic [31:0] den;
        logic [31:0] ppr;
    } gsp_cfg_t;
    typedef struct packed {
        logic a;
        logic a_n;
        logic b;
        logic b_n;
        logic c;
        logic c_n;
    } gsp_quad_t;
    typedef struct packed {
        gsp_cfg_t shadow;
        gsp_cfg_t active;
        logic dir_sel;
        logic dph;
        logic dwr;
        logic [7:0] daddr;
        logic ready;
        logic [31:0] rdata;
        gsp_div_t div;
        logic [31:0] delta;
        logic [63:0] quo;
        logic [63:0] rem;
        logic neg;
        logic [6:0] cnt;
        logic [63:0] carry;
        logic [31:0] cmd_pos;
        logic [31:0] cmd_out;
        logic cmd_valid;
        logic [31:0] acc;
        logic [31:0] qs;
        gsp_quad_t quad;
        logic gear_al;
        logic pulse_al;
    } gsp_state_t;
endpackage
`default_nettype wire

//--- test/gsp_host_model.sv
// Host controller model that counts the quadrature feedback
`timescale 1ns/10ps
`default_nettype none
module gsp_host_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic qa,
    input wire logic qa_n,
    input wire logic qb,
    input wire logic qb_n,
    input wire logic qc,
    input wire logic qc_n,
    output logic [31:0] pos,
    output logic [31:0] idx_cnt,
    output logic [31:0] err_cnt
);
    logic [1:0] prev_q;
    logic prev_a;
    logic prev_c;
    logic [1:0] now_q;
    logic [1:0] step;
    assign now_q = {qb, qa ^ qb};
    assign step = now_q - prev_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_q <= 2'h0;
            prev_a <= 1'b0;
            prev_c <= 1'b0;
            pos <= 32'h0;
            idx_cnt <= 32'h0;
            err_cnt <= 32'h0;
        end
        else
        begin
            prev_q <= now_q;
            prev_a <= qa;
            prev_c <= qc;
            if (step == 2'h1)
                pos <= pos + 32'h1;
            else if (step == 2'h3)
                pos <= pos - 32'h1;
            if (step == 2'h2 || qa_n !== ~qa || qb_n !== ~qb || qc_n !== ~qc || (qc != prev_c && qa == prev_a))
                err_cnt <= err_cnt + 32'h1;
            if (qc && !prev_c)
                idx_cnt <= idx_cnt + 32'h1;
        end
    end
endmodule
`default_nettype wire

//--- test/gsp_gear_pulse_tb.sv
// Testbench for the gear scaling and pulse output block
`timescale 1ns/10ps
`default_nettype none
`include "gsp_map.svh"
module gsp_gear_pulse_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic enc_step = 1'b0;
    logic enc_dir = 1'b0;
    logic ce = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, cmd_valid, gear_alarm, pulse_alarm;
    logic qa, qa_n, qb, qb_n, qc, qc_n;
    logic [31:0] hrdata, cmd_counts, pos, idx_cnt, err_cnt, rd;
    logic [31:0] gn[6] = '{32'hfa0, 32'hfa1, 32'h1, 32'h1, 32'h40000000, 32'h40000001};
    logic [31:0] gd[6] = '{32'h1, 32'h1, 32'h3e8, 32'h3e9, 32'h40000000, 32'h40000001};
    logic [31:0] gp[6] = '{32'h10, 32'h10, 32'h800, 32'hf, 32'h801, 32'h10};
    logic ga[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic pa[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    int bad_count = 0;
    int cmp_count = 0;
    int k;
    longint carry, acc, n, d, dl, e;
    always #20 hclk = ~hclk;
    gsp_gear_pulse #(.ENC_RES(32'h2000)) DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enc_step(enc_step), .enc_dir(enc_dir),
        .quad_out_a(qa), .quad_out_a_n(qa_n), .quad_out_b(qb), .quad_out_b_n(qb_n), .index_out(qc),
        .index_out_n(qc_n), .cmd_counts(cmd_counts), .cmd_valid(cmd_valid), .gear_alarm(gear_alarm),
        .pulse_alarm(pulse_alarm));
    gsp_host_model host (.hclk(hclk), .hresetn(hresetn), .qa(qa), .qa_n(qa_n), .qb(qb), .qb_n(qb_n),
        .qc(qc), .qc_n(qc_n), .pos(pos), .idx_cnt(idx_cnt), .err_cnt(err_cnt));
    task stop_test;
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_sig(input logic sel);
        int i;
        i = 0;
        @(posedge hclk);
        while ((sel ? cmd_valid : hreadyout) !== 1'b1 && i < 300)
        begin
            @(posedge hclk);
            i++;
        end
        if (i == 300)
        begin
            bad_count++;
            stop_test();
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] dt);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_sig(1'b0);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= dt;
        wait_sig(1'b0);
        rd = hrdata;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task steps(input int cnt, input logic dir);
        enc_dir <= dir;
        repeat (cnt)
        begin
            enc_step <= 1'b1;
            @(posedge hclk);
        end
        enc_step <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    function automatic longint scale(input longint dv, input longint nv, input longint dnv, inout longint c);
        longint t;
        t = dv * nv + c;
        c = t % dnv;
        return t / dnv;
    endfunction
    initial
    begin
        void'($urandom(84866));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(`GSP_OFF_GEAR_NUM, 32'h1);
        rdc(`GSP_OFF_GEAR_DEN, 32'h1);
        rdc(`GSP_OFF_PPR, 32'h800);
        rdc(`GSP_OFF_STATUS, 32'h0);
        rdc(8'h40, 32'h0);
        for (k = 0; k < 6; k++)
        begin
            xfer(1'b1, `GSP_OFF_GEAR_NUM, gn[k]);
            xfer(1'b1, `GSP_OFF_GEAR_DEN, gd[k]);
            xfer(1'b1, `GSP_OFF_PPR, gp[k]);
            xfer(1'b1, `GSP_OFF_CTRL, 32'h2);
            repeat (3) @(posedge hclk);
            chk({31'h0, gear_alarm}, {31'h0, ga[k]});
            chk({31'h0, pulse_alarm}, {31'h0, pa[k]});
            if (pa[k])
                steps(32'h100, 1'b1);
            rdc(`GSP_OFF_OUT_POS, 32'h0);
        end
        xfer(1'b1, `GSP_OFF_POS_REF, 32'h5);
        rdc(`GSP_OFF_STATUS, 32'h1);
        rdc(`GSP_OFF_CMD_POS, 32'h0);
        xfer(1'b1, `GSP_OFF_GEAR_NUM, 32'h1);
        xfer(1'b1, `GSP_OFF_GEAR_DEN, 32'h3);
        xfer(1'b1, `GSP_OFF_PPR, 32'h10);
        xfer(1'b1, `GSP_OFF_CTRL, 32'h3);
        steps(32'h2000, 1'b1);
        chk(pos, 32'h40);
        chk(idx_cnt, 32'h1);
        rdc(`GSP_OFF_OUT_POS, 32'h0);
        steps(32'h2000, 1'b0);
        chk(pos, 32'h0);
        chk(idx_cnt, 32'h2);
        chk(err_cnt, 32'h0);
        ce <= 1'b0;
        steps(32'h100, 1'b1);
        ce <= 1'b1;
        chk(pos, 32'h0);
        rdc(`GSP_OFF_OUT_POS, 32'h0);
        carry = 0;
        acc = 0;
        n = 1;
        d = 3;
        for (k = 0; k < 8; k++)
        begin
            if (k == 4)
            begin
                n = $urandom_range(32'hfa0, 32'h1);
                d = $urandom_range(32'h3e8, 32'h1);
                xfer(1'b1, `GSP_OFF_GEAR_NUM, n[31:0]);
                xfer(1'b1, `GSP_OFF_GEAR_DEN, d[31:0]);
                xfer(1'b1, `GSP_OFF_CTRL, 32'h2);
                carry = 0;
                acc = 0;
            end
            dl = (k < 4) ? ((k % 2) ? -2 : 1) : longint'($urandom_range(32'h30d40, 32'h0)) - 100000;
            xfer(1'b1, `GSP_OFF_POS_REF, dl[31:0]);
            wait_sig(1'b1);
            e = scale(dl, n, d, carry);
            acc += e;
            chk(cmd_counts, e[31:0]);
            rdc(`GSP_OFF_CMD_POS, acc[31:0]);
        end
        xfer(1'b1, `GSP_OFF_POS_REF, 32'h7);
        rdc(`GSP_OFF_STATUS, 32'h4);
        xfer(1'b1, `GSP_OFF_POS_REF, 32'hfffffffd);
        wait_sig(1'b1);
        e = scale(7, n, d, carry);
        acc += e;
        e = scale(-3, n, d, carry);
        acc += e;
        chk(cmd_counts, e[31:0]);
        rdc(`GSP_OFF_CMD_POS, acc[31:0]);
        xfer(1'b1, `GSP_OFF_POS_REF, 32'h7);
        xfer(1'b1, `GSP_OFF_CTRL, 32'h2);
        rdc(`GSP_OFF_STATUS, 32'h0);
        rdc(`GSP_OFF_CMD_POS, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
